// [rtl/pllsc_defines.svh]
// Function
// - Source pin high during reset selects the locked synthesizer, set by the control register.
// - Source pin low during reset disables synthesizer; outside drives the external clock.
// - Divide select bit 0, its reset value, gives system clock a quarter of oscillator.
// - Divide select bit 1 gives system clock half of oscillator frequency.
// - Changing the divide select bit takes effect at once with no relock.
// - A write changing W, or Y in the slow variant, changes oscillator and starts a relock interval.
// - Lock flag shows lock; any comparator input change requires relock.
// - At power-up with the source pin high the chip stays held in reset until the synthesizer locks.
// - Slow variant feedback uses one W bit and six Y bits, up to 256.
// - Slow variant: sys = 4 * ref * (Y+1) * 2^(2W+X).
// - Control register resets to 3f00, giving 8.388 MHz from nominal reference.
// - Fast variant: W multiplies in feedback; Y and X divide output without disturbing lock.
// - Fast variant: sys = ref / 128 * 4 * (Y+1) * 2^(2W+X).
`ifndef PLLSC_DEFINES_SVH
`define PLLSC_DEFINES_SVH

// Register byte offsets
`define PLLSC_OFS_SYNTH   8'h00
`define PLLSC_OFS_ISTAT   8'h04
`define PLLSC_OFS_IEN     8'h08
`define PLLSC_OFS_ICLR    8'h0c
`define PLLSC_OFS_STATUS  8'h10

// Control register fields and reset value
`define PLLSC_W_BIT       15
`define PLLSC_X_BIT       14
`define PLLSC_Y_MSB       13
`define PLLSC_Y_LSB       8
`define PLLSC_LOCK_BIT    3
`define PLLSC_SYNTH_RST   16'h3f00

// Interrupt status bits
`define PLLSC_INT_GAIN    0
`define PLLSC_INT_LOSS    1

// Ratio outputs are f_out / f_ref scaled by 128
`define PLLSC_SLOW_SHIFT  9
`define PLLSC_FAST_SHIFT  2

// Relock time
`define PLLSC_CLK_MHZ      10
`define PLLSC_LOCK_TIME_US 20000
`define PLLSC_LOCK_CYCLES  (`PLLSC_LOCK_TIME_US * `PLLSC_CLK_MHZ)

`define PLLSC_RESP_OKAY   2'h0
`define PLLSC_RESP_SLVERR 2'h2

`endif

// [rtl/pllsc_pkg.sv]
`default_nettype none
package pllsc_pkg;
  typedef enum logic [1:0] {PLLSC_ST_STRAP, PLLSC_ST_HOLD, PLLSC_ST_RUN} pllsc_mode_e;
  typedef logic [23:0] pllsc_ratio_t;
endpackage : pllsc_pkg
`default_nettype wire

// [rtl/pllsc_lock_timer.sv]
`include "pllsc_defines.svh"
`default_nettype none
module pllsc_lock_timer #(
  parameter logic [17:0] LOCK_CYCLES = 18'(`PLLSC_LOCK_CYCLES)
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic restart,
  output logic      locked
);
  logic [17:0] cnt;
  logic [17:0] next_cnt;
  logic        next_locked;

  always_comb begin
    next_cnt    = cnt;
    next_locked = locked;
    if (restart || !enable) begin
      next_cnt    = 18'h0;
      next_locked = 1'b0;
    end else if (!locked) begin
      if (cnt >= LOCK_CYCLES - 18'h1) begin
        next_locked = 1'b1;
      end else begin
        next_cnt = cnt + 18'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt    <= 18'h0;
      locked <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      locked <= next_locked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  relock_drop_a: assert property (@(posedge clk) disable iff (rst)
    restart |=> !locked) else $error("lock held across a relock request");
  lock_wait_a: assert property (@(posedge clk) disable iff (rst)
    $rose(locked) |-> $past(cnt) >= LOCK_CYCLES - 18'h1)
    else $error("lock came before the relock interval ended");
endmodule : pllsc_lock_timer
`default_nettype wire

// [rtl/pllsc_top.sv]
`include "pllsc_defines.svh"
`default_nettype none
module pllsc_top #(
  parameter logic [17:0] LOCK_CYCLES = 18'(`PLLSC_LOCK_CYCLES),
  parameter bit          FAST_REF    = 1'b0
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        CLOCK_SOURCE_SELECT_PIN,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             PLL_ENABLE,
  output logic             EXTERNAL_CLOCK_INPUT_MODE,
  output logic             SYS_DIV_HALF,
  output logic [23:0]      SYS_RATIO,
  output logic [23:0]      VCO_RATIO,
  output logic             LOCK_FLAG_BIT,
  output logic             CHIP_RESET_HOLD,
  output logic             IRQ
);
  ////////////////////////////////////////////////////////////////////////////
  // Strap pin synchroniser, no reset so it samples while RST is high
  logic sel_meta;
  logic sel_sync;
  always_ff @(posedge CORE_CLK) begin
    sel_meta <= CLOCK_SOURCE_SELECT_PIN;
    sel_sync <= sel_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sequencing
  pllsc_pkg::pllsc_mode_e state;
  pllsc_pkg::pllsc_mode_e next_state;
  logic pll_sel;
  logic next_pll_sel;
  logic por_hold;
  logic next_por_hold;
  logic locked;

  always_comb begin
    next_state   = state;
    next_pll_sel = pll_sel;
    unique case (state)
      pllsc_pkg::PLLSC_ST_STRAP: begin
        next_pll_sel = sel_sync;
        next_state   = pllsc_pkg::PLLSC_ST_HOLD;
      end
      pllsc_pkg::PLLSC_ST_HOLD: begin
        if (!pll_sel || locked) begin
          next_state = pllsc_pkg::PLLSC_ST_RUN;
        end
      end
      pllsc_pkg::PLLSC_ST_RUN: begin
        next_state = pllsc_pkg::PLLSC_ST_RUN;
      end
    endcase
    next_por_hold = (next_state != pllsc_pkg::PLLSC_ST_RUN);
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state    <= pllsc_pkg::PLLSC_ST_STRAP;
      pll_sel  <= 1'b0;
      por_hold <= 1'b1;
    end else begin
      state    <= next_state;
      pll_sel  <= next_pll_sel;
      por_hold <= next_por_hold;
    end
  end

  logic pll_on;
  assign pll_on                    = pll_sel && (state != pllsc_pkg::PLLSC_ST_STRAP);
  assign PLL_ENABLE                = pll_on;
  assign EXTERNAL_CLOCK_INPUT_MODE = !pll_sel && (state != pllsc_pkg::PLLSC_ST_STRAP);
  assign CHIP_RESET_HOLD           = por_hold;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        next_aw_held;
  logic [7:0]  next_aw_addr;
  logic        next_w_held;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        do_write;

  logic [15:0] ctrl;
  logic [1:0]  istat;
  logic [1:0]  ien;

  assign AWREADY  = !aw_held && !bvalid;
  assign WREADY   = !w_held && !bvalid;
  assign ARREADY  = !rvalid;
  assign BVALID   = bvalid;
  assign BRESP    = bresp;
  assign RVALID   = rvalid;
  assign RDATA    = rdata;
  assign RRESP    = rresp;
  assign do_write = aw_held && w_held && !bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (AWVALID && AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      unique case (aw_addr)
        `PLLSC_OFS_SYNTH, `PLLSC_OFS_IEN, `PLLSC_OFS_ICLR: next_bresp = `PLLSC_RESP_OKAY;
        default: next_bresp = `PLLSC_RESP_SLVERR;
      endcase
    end
    if (bvalid && BREADY) begin
      next_bvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp  = `PLLSC_RESP_OKAY;
      unique case (ARADDR)
        `PLLSC_OFS_SYNTH: begin
          next_rdata = {16'h0, ctrl[15:8], 4'h0, locked, 3'h0};
        end
        `PLLSC_OFS_ISTAT:  next_rdata = {30'h0, istat};
        `PLLSC_OFS_IEN:    next_rdata = {30'h0, ien};
        `PLLSC_OFS_ICLR:   next_rdata = 32'h0;
        `PLLSC_OFS_STATUS: next_rdata = {29'h0, por_hold, locked, pll_sel};
        default: begin
          next_rdata = 32'h0;
          next_rresp = `PLLSC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && RREADY) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h0;
      w_held  <= 1'b0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register, relock request and frequency ratios
  logic [15:0] next_ctrl;
  logic        relock;
  logic [23:0] next_sys_ratio;
  logic [23:0] next_vco_ratio;
  logic [23:0] sys_ratio;
  logic [23:0] vco_ratio;
  logic        wr_ctrl;
  logic        w_chg;
  logic        y_chg;

  assign wr_ctrl = do_write && (aw_addr == `PLLSC_OFS_SYNTH) && w_strb[1];

  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      // Lock flag lives in the low byte and is never stored
      next_ctrl[15:8] = w_data[15:8];
    end
    w_chg  = next_ctrl[`PLLSC_W_BIT] != ctrl[`PLLSC_W_BIT];
    y_chg  = next_ctrl[`PLLSC_Y_MSB:`PLLSC_Y_LSB] != ctrl[`PLLSC_Y_MSB:`PLLSC_Y_LSB];
    // Fast variant keeps Y outside the loop, so only W disturbs lock
    relock = pll_on && (w_chg || (!FAST_REF && y_chg));
    next_sys_ratio = 24'h0;
    if (pll_on) begin
      next_sys_ratio = {17'h0, 7'(next_ctrl[`PLLSC_Y_MSB:`PLLSC_Y_LSB]) + 7'h1}
        << ((FAST_REF ? `PLLSC_FAST_SHIFT : `PLLSC_SLOW_SHIFT)
            + 2 * next_ctrl[`PLLSC_W_BIT] + next_ctrl[`PLLSC_X_BIT]);
    end
    // X sits after the loop: oscillator is 4x or 2x the system clock
    next_vco_ratio = next_ctrl[`PLLSC_X_BIT] ? {next_sys_ratio[22:0], 1'b0}
                                             : {next_sys_ratio[21:0], 2'b0};
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl      <= `PLLSC_SYNTH_RST;
      sys_ratio <= 24'h0;
      vco_ratio <= 24'h0;
    end else begin
      ctrl      <= next_ctrl;
      sys_ratio <= next_sys_ratio;
      vco_ratio <= next_vco_ratio;
    end
  end

  assign SYS_DIV_HALF  = ctrl[`PLLSC_X_BIT];
  assign SYS_RATIO     = sys_ratio;
  assign VCO_RATIO     = vco_ratio;
  assign LOCK_FLAG_BIT = locked;

  pllsc_lock_timer #(
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_lock (
    .clk     (CORE_CLK),
    .rst     (RST),
    .enable  (pll_on),
    .restart (relock),
    .locked  (locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: lock gained and lock lost
  logic       locked_d;
  logic [1:0] next_istat;
  logic [1:0] next_ien;
  logic [1:0] iset;
  logic [1:0] iclr;

  always_comb begin
    iset                   = 2'h0;
    iset[`PLLSC_INT_GAIN]  = locked && !locked_d;
    iset[`PLLSC_INT_LOSS]  = !locked && locked_d;
    iclr                   = 2'h0;
    if (do_write && aw_addr == `PLLSC_OFS_ICLR && w_strb[0]) begin
      iclr = w_data[1:0];
    end
    // A new event beats a clear in the same cycle
    next_istat = (istat & ~iclr) | iset;
    next_ien   = ien;
    if (do_write && aw_addr == `PLLSC_OFS_IEN && w_strb[0]) begin
      next_ien = w_data[1:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      locked_d <= 1'b0;
      istat    <= 2'h0;
      ien      <= 2'h0;
    end else begin
      locked_d <= locked;
      istat    <= next_istat;
      ien      <= next_ien;
    end
  end

  assign IRQ = |(istat & ien);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  logic ctrl_written;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_written <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_written <= 1'b1;
    end
  end

  sequence wy_write_s;
    wr_ctrl && pll_on && (w_chg || (!FAST_REF && y_chg));
  endsequence

  sequence x_only_write_s;
    wr_ctrl && !w_chg && !y_chg && locked;
  endsequence

  strap_mode_a: assert property (
    (state == pllsc_pkg::PLLSC_ST_STRAP) |=> (PLL_ENABLE == $past(sel_sync)))
    else $error("clock source not taken from the strap");
  ext_mode_a: assert property (
    EXTERNAL_CLOCK_INPUT_MODE |-> !PLL_ENABLE && !LOCK_FLAG_BIT && SYS_RATIO == 24'h0)
    else $error("synthesizer active in external clock mode");
  reset_value_a: assert property (
    !ctrl_written |-> ctrl == `PLLSC_SYNTH_RST)
    else $error("control register left its reset value unwritten");
  relock_start_a: assert property (
    wy_write_s |=> !LOCK_FLAG_BIT ##1 !LOCK_FLAG_BIT)
    else $error("lock kept across a W or Y change");
  x_no_relock_a: assert property (
    x_only_write_s |=> LOCK_FLAG_BIT && SYS_DIV_HALF == $past(w_data[`PLLSC_X_BIT]))
    else $error("divide select caused a relock or was not applied");
  vco_div_a: assert property (
    pll_on && !SYS_DIV_HALF |-> VCO_RATIO == {SYS_RATIO[21:0], 2'b0})
    else $error("oscillator not four times system clock");
  vco_half_a: assert property (
    pll_on && SYS_DIV_HALF |-> VCO_RATIO == {SYS_RATIO[22:0], 1'b0})
    else $error("oscillator not twice system clock");
  ratio_calc_a: assert property (
    pll_on && $past(pll_on) && $stable(ctrl) |-> SYS_RATIO == 24'(({17'h0, 7'(ctrl[13:8]) + 7'h1}
      << ((FAST_REF ? 2 : 9) + 2 * ctrl[15] + ctrl[14]))))
    else $error("system clock ratio does not follow the formula");
  por_hold_a: assert property (
    pll_sel && !locked && state != pllsc_pkg::PLLSC_ST_RUN |=> CHIP_RESET_HOLD)
    else $error("reset released before lock");
  lock_read_a: assert property (
    ARVALID && ARREADY && ARADDR == `PLLSC_OFS_SYNTH |=> RDATA[3] == $past(locked))
    else $error("lock flag read does not show lock state");
  irq_level_a: assert property (
    $rose(locked) |=> istat[`PLLSC_INT_GAIN])
    else $error("lock gain not recorded");
endmodule : pllsc_top
`default_nettype wire

// [bench/pllsc_top_bench.sv]
`default_nettype none
module pllsc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // Short lock count keeps each relock wait to twenty cycles
  localparam logic [17:0] LOCK_N = 18'h00014;
  logic        core_clk, rst, src_sel, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic        pll_en, ext_mode, div_half, lock, hold, irq, f_lock;
  logic [23:0] sys_ratio, vco_ratio, f_sys;
  logic [31:0] wr_tab [2];
  logic [31:0] sys_tab [2];
  logic [31:0] fsys_tab [2];
  int          error_cnt, n_checks;

  //////////////////////////////////////////////////////////////////////////////////////////
  pllsc_top #(.LOCK_CYCLES(LOCK_N), .FAST_REF(1'b0)) uut (
    .CORE_CLK(core_clk), .RST(rst), .CLOCK_SOURCE_SELECT_PIN(src_sel),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .PLL_ENABLE(pll_en),
    .EXTERNAL_CLOCK_INPUT_MODE(ext_mode), .SYS_DIV_HALF(div_half), .SYS_RATIO(sys_ratio),
    .VCO_RATIO(vco_ratio), .LOCK_FLAG_BIT(lock), .CHIP_RESET_HOLD(hold), .IRQ(irq));

  // Fast variant shadows the same bus traffic; only its ratio and lock are watched
  pllsc_top #(.LOCK_CYCLES(LOCK_N), .FAST_REF(1'b1)) uut_fast (
    .CORE_CLK(core_clk), .RST(rst), .CLOCK_SOURCE_SELECT_PIN(src_sel),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(), .BRESP(), .BVALID(), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(), .RDATA(), .RRESP(),
    .RVALID(), .RREADY(rready), .PLL_ENABLE(), .EXTERNAL_CLOCK_INPUT_MODE(),
    .SYS_DIV_HALF(), .SYS_RATIO(f_sys), .VCO_RATIO(), .LOCK_FLAG_BIT(f_lock),
    .CHIP_RESET_HOLD(), .IRQ());

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic hang(input string nm);
    error_cnt++;
    $display("wrong value %s expected answer seen timeout", nm);
    test_done();
  endtask : hang

  // Ready is sampled at the falling edge, so the handshake edge is known before it comes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge core_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge core_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    hang("write response");
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    logic ta, tr;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(negedge core_clk);
      ta = arvalid && arready;
      tr = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge core_clk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    hang("read data");
  endtask : rd_reg

  task automatic wait_lock;
    for (int k = 0; k < 100; k++) begin
      @(negedge core_clk);
      if (lock === 1'b1) return;
    end
    hang("lock flag");
  endtask : wait_lock

  task automatic do_reset(input logic strap);
    @(posedge core_clk);
    rst <= 1'b1;
    src_sel <= strap;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    chk("hold in reset", 32'h1, {31'h0, hold});
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    src_sel = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    error_cnt = 0;
    n_checks = 0;
    // X stays set for the faster settings so the system clock runs at half the oscillator
    wr_tab = '{32'h0000ff08, 32'h0000fe00};
    sys_tab = '{32'h00040000, 32'h0003f000};
    fsys_tab = '{32'h00000800, 32'h000007e0};
    do_reset(1'b1);
    chk("pll enable", 32'h1, {31'h0, pll_en});
    chk("ext mode", 32'h0, {31'h0, ext_mode});
    chk("hold before lock", 32'h1, {31'h0, hold});
    chk("lock at start", 32'h0, {31'h0, lock});
    chk("div half", 32'h0, {31'h0, div_half});
    chk("sys ratio", 32'h00008000, {8'h00, sys_ratio});
    chk("vco ratio", 32'h00020000, {8'h00, vco_ratio});
    chk("fast sys ratio", 32'h00000100, {8'h00, f_sys});
    rd_reg(8'h00);
    chk("ctrl reset", 32'h00003f00, rd);
    wait_lock();
    repeat (2) @(negedge core_clk);
    chk("hold after lock", 32'h0, {31'h0, hold});
    rd_reg(8'h00);
    chk("ctrl locked", 32'h00003f08, rd);
    wr(8'h00, 32'h00007f00);
    @(negedge core_clk);
    chk("lock kept", 32'h1, {31'h0, lock});
    chk("div half set", 32'h1, {31'h0, div_half});
    chk("sys ratio x", 32'h00010000, {8'h00, sys_ratio});
    chk("vco ratio x", 32'h00020000, {8'h00, vco_ratio});
    // First entry changes W and tries the lock bit; second changes Y alone
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, wr_tab[i]);
      @(negedge core_clk);
      chk("lock dropped", 32'h0, {31'h0, lock});
      chk("sys ratio wy", sys_tab[i], {8'h00, sys_ratio});
      chk("fast sys ratio", fsys_tab[i], {8'h00, f_sys});
      chk("fast lock", {31'h0, i[0]}, {31'h0, f_lock});
      rd_reg(8'h00);
      chk("ctrl relocking", wr_tab[i] & 32'h0000fff0, rd);
      wait_lock();
    end
    rd_reg(8'h04);
    chk("istat", 32'h3, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(8'h08, 32'h2);
    @(negedge core_clk);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(8'h08, 32'h0);
    @(negedge core_clk);
    chk("irq mask", 32'h0, {31'h0, irq});
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h2);
    chk("clear resp", 32'h0, {30'h0, rs});
    @(negedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd_reg(8'h04);
    chk("istat cleared", 32'h1, rd);
    rd_reg(8'h10);
    chk("status", 32'h3, rd);
    wr(8'h04, 32'h0);
    chk("ro write resp", 32'h2, {30'h0, rs});
    rd_reg(8'h14);
    chk("unmapped resp", 32'h2, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
    // Second reset in mid-run with the strap low
    do_reset(1'b0);
    chk("ext mode", 32'h1, {31'h0, ext_mode});
    chk("pll off", 32'h0, {31'h0, pll_en});
    chk("hold ext", 32'h0, {31'h0, hold});
    chk("sys ratio ext", 32'h0, {8'h00, sys_ratio});
    wr(8'h00, 32'h00000100);
    repeat (30) @(negedge core_clk);
    chk("no lock ext", 32'h0, {31'h0, lock});
    rd_reg(8'h00);
    chk("ctrl ext", 32'h00000100, rd);
    test_done();
  end
endmodule : pllsc_top_bench
`default_nettype wire
